// [src/output_clock_resync.v]
// Output data clock realignment, calibration gating and result coding.
//
// Summary of operation
// - Realignment pulse accepted asynchronously at any time.
// - Clock held at mode-dependent level during pulse.
// - One shortened clock pulse on arrival allowed.
// - Next falling edge after release fixes phase.
// - Restart after fixed latency, same as normal.
// - Results saturate to 00h or FFh.
// - Out-of-range flag follows out-of-range interval.
// - Offset binary coding, zero gives mid code.
// - Calibration flag high throughout calibration.
// - Output clock inactive during calibration.
// - Flag set when either bus clips.
`timescale 1ns/1ps
`default_nettype none
`include "resync_defs.vh"
module output_clock_resync #(
    parameter RAW_W = 10,
    parameter CAL_LEN = `CAL_CYCLES
) (
    // Sampling clock and synchronous reset.
    input wire clock_i,
    input wire rst_b_i,
    // Asynchronous requests and same-domain mode controls.
    input wire output_clock_realign_pulse_i,
    input wire ddr_mode_i,
    input wire edge_sel_i,
    input wire cal_start_i,
    // Unclipped results of both converters.
    input wire signed [RAW_W-1:0] raw_a_i,
    input wire signed [RAW_W-1:0] raw_b_i,
    // Output clock, calibration status and coded results.
    output wire output_data_clock_o,
    output reg calibration_active_flag_o,
    output wire [7:0] code_a_o,
    output wire [7:0] code_b_o,
    output reg out_of_range_o
);
    // Restart latency in cycles, the same as in normal running.
    localparam [3:0] LAT_CYC = `LAT_CYCLES;
    // Realignment states.
    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_HOLD = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    // Level at which the output clock rests while frozen: low in double
    // rate, the edge select level in single rate.
    function hold_level;
        input ddr;
        input edge_cfg;
        begin
            hold_level = ddr ? 1'b0 : edge_cfg;
        end
    endfunction

    // True in every state but the running one.
    function frozen;
        input [1:0] st;
        begin
            frozen = (st != ST_RUN);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the asynchronous pins.
    // Only the second stage of each chain feeds logic, so a metastable
    // first stage never reaches the state machine.
    reg pulse_s1_q;
    reg pulse_s2_q;
    reg cal_s1_q;
    reg cal_s2_q;
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            pulse_s1_q <= 1'b0;
            pulse_s2_q <= 1'b0;
            cal_s1_q <= 1'b0;
            cal_s2_q <= 1'b0;
        end else begin
            pulse_s1_q <= output_clock_realign_pulse_i;
            pulse_s2_q <= pulse_s1_q;
            cal_s1_q <= cal_start_i;
            cal_s2_q <= cal_s1_q;
        end
    end

    // Release is retimed to the falling edge so phase fixes there.
    // A release seen on a rising edge is confirmed half a cycle later,
    // which is the edge that fixes the phase of the output clock.
    reg pulse_n_q;
    always @(negedge clock_i) begin
        if (!rst_b_i) begin
            pulse_n_q <= 1'b0;
        end else begin
            pulse_n_q <= pulse_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration cycle.
    // A start request is ignored while the synchronised realignment pulse is high, because a
    // pulse arriving during calibration would corrupt the stored result.
    // Once started, the flag stays high for exactly CAL_LEN cycles and the
    // output clock stays low for the whole of that time.
    reg [15:0] cal_cnt_q;
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            calibration_active_flag_o <= 1'b0;
            cal_cnt_q <= 16'h0000;
        end else if (calibration_active_flag_o) begin
            if (cal_cnt_q == CAL_LEN[15:0] - 16'h0001) begin
                calibration_active_flag_o <= 1'b0;
            end
            cal_cnt_q <= cal_cnt_q + 16'h0001;
        end else if (cal_s2_q && !pulse_s2_q) begin
            calibration_active_flag_o <= 1'b1;
            cal_cnt_q <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Realignment state and output clock.
    // HOLD freezes the clock while the pulse is seen high. WAIT counts the
    // restart latency once the falling-edge copy confirms the release, so
    // devices released on the same rising edge restart together.
    reg [1:0] state_q;
    reg [3:0] lat_q;
    reg phase_q;
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_q <= ST_HOLD;
            lat_q <= 4'h0;
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            case (state_q)
                // Running: a pulse freezes the clock.
                ST_RUN: begin
                    if (pulse_s2_q) begin
                        state_q <= ST_HOLD;
                    end
                end
                // Frozen: leave only when both copies of the pulse are low,
                // with the phase flop parked so that restart is repeatable.
                ST_HOLD: begin
                    phase_q <= 1'b0;
                    if (!pulse_n_q && !pulse_s2_q) begin
                        state_q <= ST_WAIT;
                        lat_q <= 4'h1;
                    end
                end
                // Latency count; a new pulse goes back to the frozen state.
                ST_WAIT: begin
                    phase_q <= 1'b0;
                    if (pulse_s2_q) begin
                        state_q <= ST_HOLD;
                    end else if (lat_q == LAT_CYC) begin
                        state_q <= ST_RUN;
                    end else begin
                        lat_q <= lat_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // SDR clock runs at half rate from the phase flop; DDR at full rate.
    // Entry into hold may cut a running half period short.
    // The output is combinational so that the double rate clock can follow
    // the sampling clock; calibration overrides the frozen level.
    wire run_clk;
    wire hold_lvl;
    assign run_clk = ddr_mode_i ? clock_i : phase_q;
    assign hold_lvl = hold_level(ddr_mode_i, edge_sel_i);
    reg output_data_clock_d;
    always @* begin
        if (calibration_active_flag_o) begin
            output_data_clock_d = 1'b0;
        end else if (frozen(state_q)) begin
            output_data_clock_d = hold_lvl;
        end else begin
            output_data_clock_d = run_clk ^ edge_sel_i;
        end
    end
    assign output_data_clock_o = output_data_clock_d;

    ////////////////////////////////////////////////////////////////////////
    // Conversion result coding for both buses.
    // Bus a sits in the low slice of the packed vectors, bus b above it.
    // Each bus clips on its own; only the range flag combines them.
    wire [`BUS_CNT*RAW_W-1:0] raw_w;
    wire [`BUS_CNT*`CODE_W-1:0] code_w;
    wire [`BUS_CNT-1:0] over_w;
    assign raw_w = {raw_b_i, raw_a_i};
    genvar g;
    generate
        for (g = 0; g < `BUS_CNT; g = g + 1) begin : g_bus
            code_clip #(
                .RAW_W(RAW_W)
            ) clip (
                .clock_i(clock_i),
                .rst_b_i(rst_b_i),
                .raw_i(raw_w[g*RAW_W +: RAW_W]),
                .code_o(code_w[g*`CODE_W +: `CODE_W]),
                .over_o(over_w[g])
            );
        end
    endgenerate
    assign code_a_o = code_w[`CODE_W-1:0];
    assign code_b_o = code_w[2*`CODE_W-1:`CODE_W];
    // Either bus clipping raises the shared flag.
    always @* begin
        out_of_range_o = |over_w;
    end
endmodule
`default_nettype wire

// [src/resync_defs.vh]
// Constants for the output clock resynchronisation block.
`ifndef RESYNC_DEFS_VH
`define RESYNC_DEFS_VH
`define CODE_MIN 8'h00
`define CODE_MAX 8'hFF
`define CODE_MID 8'h80
`define CLK_PERIOD_NS 50
`define LATENCY_NS 150
`define SYNC_STAGES 2
`define CAL_CYCLES 16'h0040
// Restart latency of 150 ns at a 50 ns period, counted in cycles.
`define LAT_CYCLES 4'h3
`define CODE_W 8
`define BUS_CNT 2
`endif

// [src/code_clip.v]
// Saturating 8-bit offset binary coder with out-of-range detection.
`timescale 1ns/1ps
`default_nettype none
`include "resync_defs.vh"
module code_clip #(
    parameter RAW_W = 10
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire signed [RAW_W-1:0] raw_i,
    output reg [7:0] code_o,
    output reg over_o
);
    // Raw value is signed, zero input maps to the mid code.
    wire signed [RAW_W:0] biased;
    assign biased = {raw_i[RAW_W-1], raw_i} + $signed({{(RAW_W-7){1'b0}}, `CODE_MID});
    wire low;
    wire high;
    assign low = biased[RAW_W];
    assign high = ~low & (|biased[RAW_W-1:8]);
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            code_o <= `CODE_MID;
            over_o <= 1'b0;
        end else begin
            if (low) begin
                code_o <= `CODE_MIN;
            end else if (high) begin
                code_o <= `CODE_MAX;
            end else begin
                code_o <= biased[7:0];
            end
            over_o <= low | high;
        end
    end
endmodule
`default_nettype wire

// [sim/resync_properties.sv]
// Checker for the output clock resynchronisation block.
`timescale 1ns/1ps
`default_nettype none
module resync_chk #(
    parameter RAW_W = 10
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire output_clock_realign_pulse_i,
    input wire ddr_mode_i,
    input wire edge_sel_i,
    input wire signed [RAW_W-1:0] raw_a_i,
    input wire signed [RAW_W-1:0] raw_b_i,
    input wire output_data_clock_o,
    input wire calibration_active_flag_o,
    input wire [7:0] code_a_o,
    input wire [7:0] code_b_o,
    input wire out_of_range_o
);
    wire lvl = ddr_mode_i ? 1'b0 : edge_sel_i;
    wire pr = output_clock_realign_pulse_i;
    wire cf = calibration_active_flag_o;
    wire oa = raw_a_i > 127 || raw_a_i < -128;
    wire ob = raw_b_i > 127 || raw_b_i < -128;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    property p_lo; raw_a_i < -128 |=> code_a_o == 8'h00; endproperty
    a_lo: assert property (p_lo) else $error("low clip");
    property p_hi; raw_b_i > 127 |=> code_b_o == 8'hFF; endproperty
    a_hi: assert property (p_hi) else $error("high clip");
    property p_mid; raw_a_i == 0 |=> code_a_o == 8'h80; endproperty
    a_mid: assert property (p_mid) else $error("mid code");
    property p_half; raw_b_i == 64 |=> code_b_o == 8'hC0; endproperty
    a_half: assert property (p_half) else $error("half code");
    property p_oor; 1 |=> out_of_range_o == $past(oa || ob); endproperty
    a_oor: assert property (p_oor) else $error("range flag");
    property p_hold; pr [*5] |-> output_data_clock_o == lvl; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rel; $fell(pr) |-> (output_data_clock_o == lvl) [*6];
    endproperty
    a_rel: assert property (p_rel) else $error("release");
    property p_cal; $rose(cf) |-> cf [*4] ##1 !cf; endproperty
    a_cal: assert property (p_cal) else $error("cal length");
endmodule
bind output_clock_resync resync_chk #(.RAW_W(RAW_W)) u_chk (.*);
`default_nettype wire

// [sim/pulse_ctrl.sv]
// Controller model that drives the realignment pulse.
`timescale 1ns/1ps
`default_nettype none
module pulse_ctrl (
    input wire clock_i,
    input wire cal_busy_i,
    output logic pulse_o
);
    initial pulse_o = 1'b0;
    task automatic fire(input int off, input int wid);
        wait (cal_busy_i === 1'b0);
        #(off) pulse_o = 1'b1;
        repeat (wid) @(posedge clock_i);
        #1 pulse_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the output clock resynchronisation block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock_i, rst_b_i, ddr, es, cal, pl, v;
    logic signed [9:0] ra, rb;
    logic signed [9:0] cor[6] = '{-129, -128, 0, 64, 127, 128};
    wire dk, cf, orf;
    wire [7:0] ca, cb;
    int error_cnt, n_checks, n;
    output_clock_resync #(.RAW_W(10), .CAL_LEN(4)) dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i),
        .output_clock_realign_pulse_i(pl), .ddr_mode_i(ddr),
        .edge_sel_i(es), .cal_start_i(cal), .raw_a_i(ra), .raw_b_i(rb),
        .output_data_clock_o(dk), .calibration_active_flag_o(cf),
        .code_a_o(ca), .code_b_o(cb), .out_of_range_o(orf));
    pulse_ctrl u_ctl (.clock_i(clock_i), .cal_busy_i(cf), .pulse_o(pl));
    function automatic logic [7:0] ex(input logic signed [9:0] r);
        return r > 127 ? 8'hFF : r < -128 ? 8'h00 : 8'(r + 10'sd128);
    endfunction
    function automatic logic oor(input logic signed [9:0] r);
        return r > 127 || r < -128;
    endfunction
    task automatic chk(input string s, input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic put(input logic signed [9:0] a, b);
        ra = a;
        rb = b;
        @(posedge clock_i);
        #1 chk("code_a", ca, ex(a));
        chk("code_b", cb, ex(b));
        chk("range", {7'h0, orf}, {7'h0, oor(a) | oor(b)});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        #100000 error_cnt++;
        report_and_stop();
    end
    initial begin
        {rst_b_i, ddr, es, cal, ra, rb} = 0;
        void'($urandom(39584));
        repeat (3) @(posedge clock_i);
        #1 rst_b_i = 1;
        foreach (cor[i]) put(cor[i], -cor[i]);
        repeat (40) put(10'($urandom), 10'($urandom));
        $display("coding test done");
        for (int m = 0; m < 4; m++) begin
            {ddr, es} = 2'(m);
            u_ctl.fire($urandom_range(1, 49), 6 + m);
            repeat (6) begin
                chk("hold", {7'h0, dk}, {7'h0, ~ddr & es});
                @(posedge clock_i);
                #1;
            end
            repeat (3) @(posedge clock_i);
            #1;
            n = 0;
            v = dk;
            repeat (16) begin
                #25 n += int'(dk !== v);
                v = dk;
            end
            chk("restart", 8'(n), ddr ? 8'h10 : 8'h08);
        end
        $display("realign test done");
        cal = 1;
        @(posedge clock_i);
        #1 cal = 0;
        repeat (8) if (cf !== 1'b1) @(posedge clock_i);
        #1 chk("cal_flag", {7'h0, cf}, 8'h01);
        chk("cal_clk", {7'h0, dk}, 8'h00);
        u_ctl.fire(13, 6);
        chk("cal_hold", {7'h0, dk}, {7'h0, ~ddr & es});
        $display("calibration test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
